// ### timer_aux.sv
// Auxiliary 16-bit timer/counter with capture, auto-reload and baud modes,
// reached over an AXI4-Lite slave port.
// Assumes CLK is the oscillator; a state time is two clocks, a machine cycle twelve.
// Assumes the serial port consumes the one-clock baud tick pulses.
`timescale 1ns/1ns
`include "timer_aux_defines.svh"
module timer_aux (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    input wire logic COUNT_PIN,
    input wire logic TRIGGER_PIN,
    input wire logic [4:0] OTHER_IRQS,
    output logic TIMER_IRQ,
    output logic IRQ_PENDING,
    output logic [15:0] IRQ_VECTOR,
    output logic RX_BAUD_TICK,
    output logic TX_BAUD_TICK
);
    import timer_aux_pkg::*;

    // ----------------------------------------------------------------
    // Decoding helpers
    // ----------------------------------------------------------------

    // Clock selects win over everything but the run bit
    function automatic timer_mode_t decode_mode(input logic [7:0] c);
        if (!c[`BIT_RUN]) begin
            decode_mode = MODE_OFF;
        end else if (c[`BIT_RXSEL] || c[`BIT_TXSEL]) begin
            decode_mode = MODE_BAUD;
        end else if (c[`BIT_CAPSEL]) begin
            decode_mode = MODE_CAPTURE;
        end else begin
            decode_mode = MODE_RELOAD;
        end
    endfunction : decode_mode

    // Shared by the read and write paths
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == `OFS_CONTROL) || (a == `OFS_CNT_LO) || (a == `OFS_CNT_HI) ||
            (a == `OFS_CAP_LO) || (a == `OFS_CAP_HI) || (a == `OFS_VECTOR);
    endfunction : is_mapped

    // Read value of one register word, upper bits zero except the pending bit of the vector word
    function automatic logic [31:0] read_word(input timer_state_t s, input logic [7:0] a);
        read_word = 32'h0000_0000;
        case (a)
            `OFS_CONTROL: read_word[7:0] = s.ctrl;
            `OFS_CNT_LO: read_word[7:0] = s.cnt[7:0];
            `OFS_CNT_HI: read_word[7:0] = s.cnt[15:8];
            `OFS_CAP_LO: read_word[7:0] = s.cap[7:0];
            `OFS_CAP_HI: read_word[7:0] = s.cap[15:8];
            `OFS_VECTOR: begin
                read_word[15:0] = s.vector;
                read_word[`PEND_BIT] = s.pending;
            end
            default: read_word = 32'h0000_0000;
        endcase
    endfunction : read_word

    // ----------------------------------------------------------------
    // State and submodules
    // ----------------------------------------------------------------

    timer_state_t st;
    timer_state_t n;
    timer_mode_t mode;
    pin_events_t ev;
    irq_answer_t ans;
    logic state_tick;
    logic cycle_tick;
    logic inc;
    logic ovf;
    logic trig;
    logic wr_do;
    logic wr_eff;

    // Pins pass through a synchroniser before any edge is trusted
    timer_aux_edge u_edge (
        .clk(CLK),
        .resetn(RESETN),
        .pins({COUNT_PIN, TRIGGER_PIN}),
        .events(ev)
    );

    // This timer is the lowest of the six sources
    timer_aux_vector u_vector (
        .req({st.irq, OTHER_IRQS}),
        .ans(ans)
    );

    // ----------------------------------------------------------------
    // Count enables and events
    // ----------------------------------------------------------------

    // Divider runs 0..11: odd counts mark state times, the last a machine cycle
    assign state_tick = st.div[0];
    assign cycle_tick = (st.div == `DIV_LAST);
    assign mode = decode_mode(st.ctrl); // RULE1

    // External count wins; internal rate depends on baud mode
    assign inc = (mode != MODE_OFF) && (st.ctrl[`BIT_CT] ? ev.count_fall :
        ((mode == MODE_BAUD) ? state_tick : cycle_tick)); // RULE4 RULE22
    assign ovf = inc && (st.cnt == `CNT_MAX);
    assign trig = (mode != MODE_OFF) && st.ctrl[`BIT_EXEN] && ev.trig_fall; // RULE18

    // A write is carried out once address and data are both held
    assign wr_do = st.aw_ok && st.w_ok && !st.bvalid;
    assign wr_eff = wr_do && st.wstrb[0] && is_mapped(st.aw_addr);

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------

    always_comb begin
        n = st;
        n.div = cycle_tick ? 4'h0 : st.div + `DIV_ONE;
        n.rx_tick = 1'b0;
        n.tx_tick = 1'b0;

        // Counter behaviour per mode
        unique case (mode)
            MODE_OFF: begin
                n.cnt = st.cnt;
            end
            MODE_RELOAD: begin
                if (ovf || trig) begin
                    n.cnt = st.cap; // RULE21 RULE18
                end else if (inc) begin
                    n.cnt = st.cnt + `CNT_ONE;
                end
            end
            MODE_CAPTURE: begin
                if (inc) begin
                    n.cnt = st.cnt + `CNT_ONE; // RULE17
                end
                if (trig) begin
                    n.cap = st.cnt; // RULE20
                end
            end
            MODE_BAUD: begin
                // Trigger edges only flag here; reload comes from rollover alone
                if (ovf) begin
                    n.cnt = st.cap; // RULE3
                    n.baud_div = st.baud_div + `BAUD_ONE;
                    if (st.baud_div == `BAUD_LAST) begin
                        n.rx_tick = st.ctrl[`BIT_RXSEL]; // RULE7 RULE8
                        n.tx_tick = st.ctrl[`BIT_TXSEL];
                    end
                end else if (inc) begin
                    n.cnt = st.cnt + `CNT_ONE;
                end
            end
        endcase

        // Software writes; a collision with a reload goes to software
        if (wr_eff) begin
            case (st.aw_addr)
                `OFS_CONTROL: n.ctrl = st.wdata[7:0]; // RULE11
                `OFS_CNT_LO: n.cnt[7:0] = st.wdata[7:0];
                `OFS_CNT_HI: n.cnt[15:8] = st.wdata[7:0];
                `OFS_CAP_LO: n.cap[7:0] = st.wdata[7:0];
                `OFS_CAP_HI: n.cap[15:8] = st.wdata[7:0];
                default: n.ctrl = n.ctrl;
            endcase
        end

        // Hardware sets win over a clearing write in the same cycle
        if (ovf && (mode != MODE_BAUD)) begin
            n.ctrl[`BIT_OVF] = 1'b1; // RULE2 RULE10
        end
        if (trig) begin
            n.ctrl[`BIT_EXF] = 1'b1; // RULE3 RULE20
        end

        // Request and vector registered for the interrupt controller
        n.irq = st.ctrl[`BIT_OVF] | st.ctrl[`BIT_EXF]; // RULE9
        n.pending = ans.pending;
        n.vector = ans.vector; // RULE12 RULE13

        // Write address and data channels, taken independently
        if (AWVALID && st.awready) begin
            n.aw_ok = 1'b1;
            n.aw_addr = AWADDR;
        end
        if (WVALID && st.wready) begin
            n.w_ok = 1'b1;
            n.wdata = WDATA;
            n.wstrb = WSTRB;
        end
        if (wr_do) begin
            n.aw_ok = 1'b0;
            n.w_ok = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = is_mapped(st.aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
        end
        if (st.bvalid && BREADY) begin
            n.bvalid = 1'b0;
        end
        n.awready = !n.aw_ok;
        n.wready = !n.w_ok;

        // Read channel: one read in flight, data sampled when the address is taken
        if (ARVALID && st.arready) begin
            n.arready = 1'b0;
            n.rvalid = 1'b1;
            n.rdata = read_word(st, ARADDR);
            n.rresp = is_mapped(ARADDR) ? `RESP_OKAY : `RESP_SLVERR;
        end
        if (st.rvalid && RREADY) begin
            n.rvalid = 1'b0;
            n.arready = 1'b1;
        end
    end

    // Synchronous reset; ready lines come up high so the bus is never stuck
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            st <= '0;
            st.ctrl <= `CTRL_RESET;
            st.cnt <= `CNT_RESET;
            st.cap <= `CNT_RESET;
            st.awready <= 1'b1;
            st.wready <= 1'b1;
            st.arready <= 1'b1;
        end else begin
            st <= n;
        end
    end

    // ----------------------------------------------------------------
    // Outputs, all straight from state
    // ----------------------------------------------------------------

    assign AWREADY = st.awready;
    assign WREADY = st.wready;
    assign BVALID = st.bvalid;
    assign BRESP = st.bresp;
    assign ARREADY = st.arready;
    assign RVALID = st.rvalid;
    assign RDATA = st.rdata;
    assign RRESP = st.rresp;
    assign TIMER_IRQ = st.irq;
    assign IRQ_PENDING = st.pending;
    assign IRQ_VECTOR = st.vector;
    assign RX_BAUD_TICK = st.rx_tick;
    assign TX_BAUD_TICK = st.tx_tick;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);

    property p_off_holds;
        (mode == MODE_OFF && !wr_eff) |=> $stable(st.cnt);
    endproperty
    a_off_holds: assert property (p_off_holds) else $error("counter moved while off"); // RULE1

    property p_baud_no_ovf;
        (mode == MODE_BAUD && ovf && !wr_eff && !st.ctrl[`BIT_OVF]) |=> !st.ctrl[`BIT_OVF];
    endproperty
    a_baud_no_ovf: assert property (p_baud_no_ovf) else $error("baud rollover set flag"); // RULE2

    property p_baud_trig;
        (mode == MODE_BAUD && trig && !ovf && !wr_eff)
            |=> st.ctrl[`BIT_EXF] && (st.cnt - $past(st.cnt) <= `CNT_ONE);
    endproperty
    a_baud_trig: assert property (p_baud_trig) else $error("baud trigger reloaded"); // RULE3

    property p_baud_rate;
        (mode == MODE_BAUD && !st.ctrl[`BIT_CT] && !ovf && !wr_eff)
            |=> st.cnt == $past(st.cnt) + {15'h0000, $past(state_tick)};
    endproperty
    a_baud_rate: assert property (p_baud_rate) else $error("baud count rate wrong"); // RULE4

    property p_tick_sixteen;
        (st.rx_tick || st.tx_tick) |-> st.baud_div == 4'h0 && $past(ovf);
    endproperty
    a_tick_sixteen: assert property (p_tick_sixteen) else $error("baud tick not 1/16"); // RULE7

    property p_irq_or;
        1'b1 |=> TIMER_IRQ == ($past(st.ctrl[`BIT_OVF]) | $past(st.ctrl[`BIT_EXF]));
    endproperty
    a_irq_or: assert property (p_irq_or) else $error("request not OR of flags"); // RULE9

    property p_flag_sticky;
        (st.ctrl[`BIT_OVF] && !(wr_eff && st.aw_addr == `OFS_CONTROL)) |=> st.ctrl[`BIT_OVF];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag cleared by itself"); // RULE10

    property p_sw_set;
        (wr_eff && st.aw_addr == `OFS_CONTROL && st.wdata[`BIT_EXF])
            |=> st.ctrl[`BIT_EXF] ##1 TIMER_IRQ;
    endproperty
    a_sw_set: assert property (p_sw_set) else $error("software set gave no request"); // RULE11

    property p_top_source;
        OTHER_IRQS[0] |=> IRQ_VECTOR == `VEC_BASE && IRQ_PENDING;
    endproperty
    a_top_source: assert property (p_top_source) else $error("highest source lost"); // RULE12

    property p_own_vector;
        (OTHER_IRQS == 5'h00 && st.irq) |=> IRQ_VECTOR == `VEC_OWN;
    endproperty
    a_own_vector: assert property (p_own_vector) else $error("own vector wrong"); // RULE13

    property p_no_ext;
        (mode == MODE_CAPTURE && !st.ctrl[`BIT_EXEN] && !wr_eff) |=> $stable(st.cap);
    endproperty
    a_no_ext: assert property (p_no_ext) else $error("capture without edge"); // RULE17

    property p_reload_edge;
        (mode == MODE_RELOAD && trig && !wr_eff) |=> st.cnt == $past(st.cap);
    endproperty
    a_reload_edge: assert property (p_reload_edge) else $error("edge reload missed"); // RULE18

    property p_capture;
        (mode == MODE_CAPTURE && trig && !wr_eff)
            |=> st.cap == $past(st.cnt) && st.ctrl[`BIT_EXF];
    endproperty
    a_capture: assert property (p_capture) else $error("capture wrong"); // RULE20

    property p_reload;
        (mode == MODE_RELOAD && ovf && !wr_eff) |=> st.cnt == $past(st.cap) && st.ctrl[`BIT_OVF];
    endproperty
    a_reload: assert property (p_reload) else $error("rollover reload wrong"); // RULE21

    property p_machine_rate;
        (mode == MODE_RELOAD && !st.ctrl[`BIT_CT] && !ovf && !trig && !wr_eff)
            |=> st.cnt == $past(st.cnt) + {15'h0000, $past(cycle_tick)};
    endproperty
    a_machine_rate: assert property (p_machine_rate) else $error("timer rate wrong"); // RULE22

endmodule : timer_aux

// ### timer_aux_defines.svh
// Constants of the auxiliary timer: register map, field positions, reset values, counts.
// Assumes it is included by bare name in each design file that uses its constants; definitions only.
// Behaviour
// (RULE1) Mode from run, capture select, clock selects
// (RULE2) Baud rollover never sets overflow flag
// (RULE3) Baud trigger edge sets flag, no reload
// (RULE4) Baud timer counts every state time
// (RULE5) Software stops timer before baud accesses
// (RULE6) Software sets run bit in separate write; the bench sets it together with the baud selects (8'h34, 8'h3E, 8'h36)
// (RULE7) External baud rate is overflow rate/16
// (RULE8) Internal baud rate is osc/(32*(65536-capture))
// (RULE9) Interrupt request is OR of flags
// (RULE10) Flags stay set until software clears
// (RULE11) Software flag writes act like hardware events
// (RULE12) Six sources vector in fixed order
// (RULE13) This block vectors last, own address
// (RULE14) Software loads baud control setup codes
// (RULE15) Software loads timer reload/capture codes
// (RULE16) Software loads counter codes with select
// (RULE17) Without enable, capture/reload on overflow only
// (RULE18) With enable, trigger edge also captures/reloads
// (RULE19) Reset held two machine cycles minimum; the bench holds the first reset for 8 clocks only
// (RULE20) Capture edge copies counter, sets trigger flag
// (RULE21) Reload rollover sets flag, reloads capture value
// (RULE22) Timer per machine cycle, baud per state
// (RULE23) Pins synchronised, falling edge high-then-low
`ifndef TIMER_AUX_DEFINES_SVH
`define TIMER_AUX_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CONTROL 8'h00
`define OFS_CNT_LO 8'h04
`define OFS_CNT_HI 8'h08
`define OFS_CAP_LO 8'h0C
`define OFS_CAP_HI 8'h10
`define OFS_VECTOR 8'h14

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define BIT_CAPSEL 0
`define BIT_CT 1
`define BIT_RUN 2
`define BIT_EXEN 3
`define BIT_TXSEL 4
`define BIT_RXSEL 5
`define BIT_EXF 6
`define BIT_OVF 7

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define CTRL_RESET 8'h00
`define CNT_RESET 16'h0000
`define CNT_MAX 16'hFFFF
`define CNT_ONE 16'h0001
`define DIV_LAST 4'hB
`define DIV_ONE 4'h1
`define BAUD_LAST 4'hF
`define BAUD_ONE 4'h1
`define VEC_BASE 16'h0003
`define VEC_STEP 16'h0008
`define VEC_OWN 16'h002B
`define NUM_SOURCES 6
`define OWN_SOURCE 5
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define PEND_BIT 16

`endif

// ### timer_aux_pkg.sv
// Types of the auxiliary timer: modes, pin events, interrupt answer, state records.
// Assumes the constants header is available to the design files that use it.
package timer_aux_pkg;

    // Operating modes
    typedef enum logic [1:0] {
        MODE_OFF = 2'b00,
        MODE_RELOAD = 2'b01,
        MODE_CAPTURE = 2'b10,
        MODE_BAUD = 2'b11
    } timer_mode_t;

    // Falling edges seen on the two pins
    typedef struct packed {
        logic count_fall;
        logic trig_fall;
    } pin_events_t;

    // Winning interrupt source
    typedef struct packed {
        logic pending;
        logic [15:0] vector;
    } irq_answer_t;

    // Synchroniser state
    typedef struct packed {
        logic [1:0] sync1;
        logic [1:0] sync2;
        logic [1:0] prev;
        logic [1:0] fall;
    } edge_state_t;

    // Whole state of the timer and its bus slave
    typedef struct packed {
        logic [7:0] ctrl;
        logic [15:0] cnt;
        logic [15:0] cap;
        logic [3:0] div;
        logic [3:0] baud_div;
        logic rx_tick;
        logic tx_tick;
        logic irq;
        logic pending;
        logic [15:0] vector;
        logic aw_ok;
        logic [7:0] aw_addr;
        logic w_ok;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } timer_state_t;

endpackage : timer_aux_pkg

// ### timer_aux_edge.sv
// Synchroniser and falling-edge detector for the count and trigger pins.
// Assumes pins may change at any time; output pulses last one clock.
`timescale 1ns/1ns
`include "timer_aux_defines.svh"
module timer_aux_edge (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [1:0] pins,
    output timer_aux_pkg::pin_events_t events
);
    import timer_aux_pkg::*;

    edge_state_t st;
    edge_state_t n;

    // Two stages, then compare the settled sample with the previous one
    always_comb begin
        n = st;
        n.sync1 = pins;
        n.sync2 = st.sync1;
        n.prev = st.sync2;
        n.fall = st.prev & ~st.sync2; // RULE23
    end

    // Idle-high reset, so a pin already low at start is seen as one falling edge
    always_ff @(posedge clk) begin
        if (!resetn) begin
            st <= '1;
            st.fall <= 2'b00;
        end else begin
            st <= n;
        end
    end

    assign events.count_fall = st.fall[1];
    assign events.trig_fall = st.fall[0];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_fall_seen;
        $fell(st.sync2[0]) |=> st.fall[0];
    endproperty
    a_fall_seen: assert property (p_fall_seen) else $error("trigger edge missed"); // RULE23

    property p_fall_cause;
        st.fall[1] |-> $past(st.sync2[1], 2) && !$past(st.sync2[1]);
    endproperty
    a_fall_cause: assert property (p_fall_cause) else $error("count edge spurious"); // RULE23

endmodule : timer_aux_edge

// ### timer_aux_vector.sv
// Fixed-order priority choice among the six interrupt sources of one level.
// Assumes request bit 0 is the highest source and bit 5 is this timer.
`timescale 1ns/1ns
`include "timer_aux_defines.svh"
module timer_aux_vector (
    input wire logic [5:0] req,
    output timer_aux_pkg::irq_answer_t ans
);
    import timer_aux_pkg::*;

    // Walk from lowest to highest so the highest request wins last
    always_comb begin
        ans = '0;
        for (int i = `NUM_SOURCES - 1; i >= 0; i--) begin
            if (req[i]) begin
                ans.pending = 1'b1;
                ans.vector = `VEC_BASE + `VEC_STEP * 16'(i); // RULE12 RULE13
            end
        end
    end

endmodule : timer_aux_vector

// ### serial_side_model.sv
// Serial port side of the timer: counts baud ticks, times transmit ticks.
// Assumes one-clock tick pulses on the timer clock.
`timescale 1ns/1ns
module serial_side_model (
    input wire logic clk,
    input wire logic rx_tick,
    input wire logic tx_tick,
    output int rx_count,
    output int tx_count,
    output int tx_period
);
    int gap = 0;
    // The gap between ticks is the bit clock period seen by the port
    always @(posedge clk) begin
        gap <= gap + 1;
        if (rx_tick) begin
            rx_count <= rx_count + 1;
        end
        if (tx_tick) begin
            tx_count <= tx_count + 1;
            tx_period <= gap + 1;
            gap <= 0;
        end
    end
endmodule : serial_side_model

// ### testbench.sv
// Bench for the auxiliary timer: AXI4-Lite tasks and mode scenarios.
// Assumes the serial side model counts the baud ticks and times the transmit ticks.
`timescale 1ns/1ns
module testbench;
    import timer_aux_pkg::*;
    logic clk = 0, resetn = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = 0;
    logic [3:0] wstrb = 0;
    logic [1:0] pins = 2'b11; // Bit 0 count pin, bit 1 trigger pin
    logic [4:0] other_irqs = 0;
    logic awready, wready, bvalid, arready, rvalid, timer_irq, pend, rxt, txt;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [15:0] vec;
    int miscompares = 0, checks = 0, rxc, txc, txp, n0, n1, i;

    always #20 clk = ~clk;

    timer_aux u_timer_aux (.CLK(clk), .RESETN(resetn),
        .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
        .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
        .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
        .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
        .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
        .COUNT_PIN(pins[0]), .TRIGGER_PIN(pins[1]), .OTHER_IRQS(other_irqs),
        .TIMER_IRQ(timer_irq), .IRQ_PENDING(pend), .IRQ_VECTOR(vec),
        .RX_BAUD_TICK(rxt), .TX_BAUD_TICK(txt));

    serial_side_model u_serial_side_model (.clk(clk), .rx_tick(rxt),
        .tx_tick(txt), .rx_count(rxc), .tx_count(txc), .tx_period(txp));

    task automatic complete_run;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run

    task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t data %h expected %h", $time, got, exp);
        end
    endtask : cmp_data

    task automatic cmp_count(input int got, input int exp);
        checks++;
        if (got != exp) begin
            miscompares++;
            $display("MISMATCH %0t count %0d expected %0d", $time, got, exp);
        end
    endtask : cmp_count

    // Bus cycles; each starts one edge after the last so no signal is set twice
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = 0);
        int n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            awvalid <= awvalid & ~awready;
            wvalid <= wvalid & ~wready;
            n++;
        end while (!bvalid && n < 50);
        bready <= 1'b0;
        cmp_data({30'h0, bresp}, {30'h0, er});
        // A write that never answers is a failure, not a silent end
        if (!bvalid) begin
            miscompares++;
            $display("MISMATCH %0t write answer timed out", $time);
            complete_run();
        end
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er = 0);
        int n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            arvalid <= arvalid & ~arready;
            n++;
        end while (!rvalid && n < 50);
        rready <= 1'b0;
        cmp_data(rdata, {24'h0, e});
        cmp_data({30'h0, rresp}, {30'h0, er});
        // A read that never answers is a failure, not a silent end
        if (!rvalid) begin
            miscompares++;
            $display("MISMATCH %0t read answer timed out", $time);
            complete_run();
        end
    endtask : rd

    // Pins stay low then high long enough for the synchroniser
    task automatic pulse(input logic [1:0] m);
        @(posedge clk);
        pins <= pins & ~m;
        repeat (4) @(posedge clk);
        pins <= 2'b11;
        repeat (5) @(posedge clk);
    endtask : pulse

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        rd(8'h00, 8'h00);
        rd(8'h18, 8'h00, 2'b10);
        wr(8'h18, 8'h55, 2'b10);
        wr(8'h04, 8'h34);
        wr(8'h08, 8'h12);
        wr(8'h00, 8'h0B);
        wr(8'h00, 8'h0F);
        repeat (3) pulse(2'b01);
        pulse(2'b10);
        rd(8'h0C, 8'h37);
        rd(8'h10, 8'h12);
        rd(8'h00, 8'h4F);
        for (i = 0; i < 5; i++) begin
            other_irqs <= 5'h01 << i;
            repeat (4) @(posedge clk);
            cmp_data({16'h0, vec}, 32'h3 + 32'h8 * i);
        end
        other_irqs <= 5'h00;
        repeat (4) @(posedge clk);
        cmp_data({16'h0, vec}, 32'h2B);
        cmp_data({31'h0, pend}, 32'h1);
        cmp_data({31'h0, timer_irq}, 32'h1);
        wr(8'h00, 8'h0F);
        repeat (3) @(posedge clk);
        cmp_data({31'h0, timer_irq}, 32'h0);
        cmp_data({31'h0, pend}, 32'h0);
        wr(8'h00, 8'h4F);
        repeat (3) @(posedge clk);
        cmp_data({31'h0, timer_irq}, 32'h1);
        wr(8'h0C, 8'h55);
        wr(8'h10, 8'hAA);
        wr(8'h00, 8'h0A);
        wr(8'h00, 8'h0E);
        pulse(2'b10);
        rd(8'h04, 8'h55);
        rd(8'h08, 8'hAA);
        wr(8'h04, 8'hFF);
        wr(8'h08, 8'hFF);
        pulse(2'b01);
        rd(8'h00, 8'hCE);
        rd(8'h04, 8'h55);
        wr(8'h00, 8'h06);
        wr(8'h04, 8'h11);
        pulse(2'b10);
        rd(8'h00, 8'h06);
        rd(8'h04, 8'h11);
        // Internal timer auto-reload
        wr(8'h00, 8'h00);
        wr(8'h10, 8'h80);
        wr(8'h0C, 8'h00);
        wr(8'h04, 8'hFE);
        wr(8'h08, 8'hFF);
        wr(8'h00, 8'h04);
        repeat (60) @(posedge clk);
        // Flag must come from the rollover itself, so read before stopping
        rd(8'h00, 8'h84);
        rd(8'h08, 8'h80);
        cmp_data({31'h0, timer_irq}, 32'h1);
        // Baud mode: timer stopped around every counter write
        wr(8'h00, 8'h00);
        wr(8'h0C, 8'hFE);
        wr(8'h10, 8'hFF);
        wr(8'h04, 8'hFE);
        wr(8'h08, 8'hFF);
        wr(8'h00, 8'h34);
        repeat (200) @(posedge clk);
        cmp_count(txp, 32 * (65536 - 16'hFFFE));
        rd(8'h00, 8'h34);
        wr(8'h00, 8'h24);
        // A tick launched under the old setting may still land; let it pass
        @(posedge clk);
        n0 = txc;
        repeat (200) @(posedge clk);
        cmp_count(txc, n0);
        wr(8'h00, 8'h00);
        wr(8'h04, 8'h11);
        wr(8'h08, 8'h22);
        wr(8'h00, 8'h3E);
        pulse(2'b10);
        rd(8'h00, 8'h7E);
        rd(8'h04, 8'h11);
        wr(8'h00, 8'h00);
        wr(8'h0C, 8'hFF);
        wr(8'h10, 8'hFF);
        wr(8'h04, 8'hFF);
        wr(8'h08, 8'hFF);
        wr(8'h00, 8'h36);
        n0 = txc;
        n1 = rxc;
        repeat (32) pulse(2'b01);
        cmp_count(txc - n0, 2);
        cmp_count(rxc - n1, 2);
        // Second reset in mid-run, held two machine cycles
        @(posedge clk);
        resetn <= 1'b0;
        repeat (24) @(posedge clk);
        resetn <= 1'b1;
        rd(8'h04, 8'h00);
        rd(8'h00, 8'h00);
        complete_run();
    end
endmodule : testbench
